// file: design/lwu_cfg_reg.sv
/*
 * One 8-bit pin edge-select register.
 * Assumes chip_rst_i is the chip reset that is not a stop recovery and
 * is asserted at power-up; the ordinary logic reset never touches it.
 */
`timescale 1ns/10ps
`default_nettype none

module lwu_cfg_reg
   import lwu_pkg::*;
(
   // Clock and retention-class reset
   input wire logic clk_i,
   input wire logic chip_rst_i,
   // Write port
   input wire logic wr_i,
   input wire logic [lwu_pkg::LWU_REG_W-1:0] wdata_i,
   // Stored value
   output logic [lwu_pkg::LWU_REG_W-1:0] value_o
);

   always_ff @(posedge clk_i) begin
      if (chip_rst_i) begin
         value_o <= LWU_CFG_RESET;
      end else if (wr_i) begin
         value_o <= wdata_i;
      end
   end
   // Other resets leave the value alone

endmodule : lwu_cfg_reg

`default_nettype wire

// file: design/lwu_edge_select.sv
/*
 * Pin edge-select register bank of the low-leakage wakeup unit for
 * wakeup pins 4 to 15, with a classic Wishbone slave and the detectors.
 * Assumes all inputs synchronous to clk_i and an external power
 * controller that signals low-leakage mode and the retention-class reset.
 */
// Notes on behaviour
// - Selector 00: pin is never a wakeup source.
// - Selector 01: pin enabled, only rising transitions detected.
// - Selector 10: pin enabled, only falling transitions detected.
// - Selector 11: pin enabled, both transition directions detected.
// - Register at index 1 holds pins 7..4, pin 7 highest.
// - Register at index 2 holds pins 11..8, pin 11 highest.
// - Register at index 3 holds pins 15..12, pin 15 highest.
// - Chip reset not from stop recovery clears all three registers.
// - Every other reset leaves the three registers unchanged.
// - Registers are 8-bit, read/write, reset to zero.
// - User-mode writes are blocked and answered with a bus error.
// - Detection only in low-leakage mode; registers always reachable.
`timescale 1ns/10ps
`default_nettype none

module lwu_edge_select
   import lwu_pkg::*;
(
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic chip_rst_i,
   // Wishbone slave
   input wire lwu_pkg::lwu_wb_req_s wb_req_i,
   input wire logic wb_priv_i,
   output lwu_pkg::lwu_wb_rsp_s wb_rsp_o,
   // Power mode
   input wire logic low_leak_mode_i,
   // Wakeup pins 15..4
   input wire logic [lwu_pkg::LWU_PIN_N-1:0] wake_pin_i,
   // Wakeup results
   output logic [lwu_pkg::LWU_PIN_N-1:0] pin_wake_o,
   output logic wake_o
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode shared by write strobes and read mux
   function automatic lwu_decode_s decode_adr(input logic [LWU_ADR_W-1:0] adr);
      lwu_decode_s d;
      logic [LWU_ADR_W-1:0] idx;
      d = '0;
      idx = {2'h0, adr[LWU_ADR_W-1:2]};
      if (adr[1:0] != LWU_ADR_ALIGN) begin
         d = '0;
      end else if (idx == LWU_IDX_PINS_7_4) begin
         d = '{hit: 1'b1, cfg: 1'b1, slot: 2'h0};
      end else if (idx == LWU_IDX_PINS_11_8) begin
         d = '{hit: 1'b1, cfg: 1'b1, slot: 2'h1};
      end else if (idx == LWU_IDX_PINS_15_12) begin
         d = '{hit: 1'b1, cfg: 1'b1, slot: 2'h2};
      end else if (idx == LWU_IDX_STATUS) begin
         d = '{hit: 1'b1, cfg: 1'b0, slot: 2'h3};
      end
      return d;
   endfunction : decode_adr

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic logic_rst;
   logic req;
   lwu_decode_s dec;
   logic [2:0] cfg_wr;
   logic [LWU_REG_W-1:0] cfg_val [3];
   logic [3*LWU_REG_W-1:0] cfg_flat;
   logic [LWU_DAT_W-1:0] next_rdata;
   logic next_err;
   logic user_write;
   lwu_state_e state;
   lwu_state_e next_state;
   logic arm;
   logic watch;
   logic [LWU_PIN_N-1:0] hit;
   logic [LWU_PIN_N-1:0] caught;
   logic [LWU_STAT_W-1:0] status;
   logic rsp_ack;
   logic rsp_err;
   logic [LWU_DAT_W-1:0] rsp_dat;

   // The retention-class reset also resets everything else
   assign logic_rst = rst_i | chip_rst_i;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   assign req = wb_req_i.cyc & wb_req_i.stb & ~rsp_ack & ~rsp_err;
   assign dec = decode_adr(wb_req_i.adr);
   assign user_write = wb_req_i.we & ~wb_priv_i;

   always_comb begin
      next_err = 1'b0;
      if (!dec.hit) begin
         next_err = 1'b1;
      end else if (user_write) begin
         next_err = 1'b1;
      end
   end

   // Writes land at the edge that sees ack; a refused write never gets ack
   genvar r;
   generate
      for (r = 0; r < 3; r++) begin : g_cfg
         assign cfg_wr[r] = rsp_ack & dec.cfg & wb_req_i.we
                            & wb_req_i.sel[0] & (dec.slot == 2'(r));
         lwu_cfg_reg u_cfg (
            .clk_i(clk_i),
            .chip_rst_i(chip_rst_i),
            .wr_i(cfg_wr[r]),
            .wdata_i(wb_req_i.dat[LWU_REG_W-1:0]),
            .value_o(cfg_val[r])
         );
      end
   endgenerate

   assign status = {watch, caught};

   always_comb begin
      next_rdata = '0;
      if (dec.cfg) begin
         next_rdata = {{(LWU_DAT_W-LWU_REG_W){1'b0}}, cfg_val[dec.slot]};
      end else if (dec.hit) begin
         next_rdata = {{(LWU_DAT_W-LWU_STAT_W){1'b0}}, status};
      end
   end

   // Answer one cycle after the request, for one cycle
   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         rsp_ack <= 1'b0;
         rsp_err <= 1'b0;
      end else begin
         rsp_ack <= req & ~next_err;
         rsp_err <= req & next_err;
      end
   end

   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         rsp_dat <= '0;
      end else if (req && !wb_req_i.we && !next_err) begin
         rsp_dat <= next_rdata;
      end
   end

   assign wb_rsp_o = '{ack: rsp_ack, err: rsp_err, dat: rsp_dat};

   ////////////////////////////////////////////////////////////////////////
   // Low-leakage mode sequencing
   always_comb begin
      next_state = state;
      case (state)
         LWU_IDLE: begin
            if (low_leak_mode_i) begin
               next_state = LWU_ARM;
            end
         end
         LWU_ARM: begin
            next_state = low_leak_mode_i ? LWU_WATCH : LWU_IDLE;
         end
         LWU_WATCH: begin
            if (!low_leak_mode_i) begin
               next_state = LWU_IDLE;
            end
         end
         default: next_state = LWU_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         state <= LWU_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign arm = (state == LWU_ARM);
   assign watch = (state == LWU_WATCH);

   ////////////////////////////////////////////////////////////////////////
   // Detectors; flat field order is pin 4 upward
   assign cfg_flat = {cfg_val[2], cfg_val[1], cfg_val[0]};

   genvar p;
   generate
      for (p = 0; p < LWU_PIN_N; p++) begin : g_pin
         lwu_pin_detect u_det (
            .clk_i(clk_i),
            .rst_i(logic_rst),
            .arm_i(arm),
            .watch_i(watch),
            .sel_i(cfg_flat[LWU_FIELD_W*p +: LWU_FIELD_W]),
            .pin_i(wake_pin_i[p]),
            .hit_o(hit[p])
         );
      end
   endgenerate

   assign pin_wake_o = hit;

   // Pins that woke the unit stay visible until the next entry
   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         caught <= '0;
      end else begin
         // A hit in the clearing cycle wins over the clear
         caught <= (arm ? '0 : caught) | hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         wake_o <= 1'b0;
      end else if (!low_leak_mode_i) begin
         wake_o <= 1'b0;
      end else if (|hit) begin
         wake_o <= 1'b1;
      end
   end

endmodule : lwu_edge_select

`default_nettype wire

// file: design/lwu_pin_detect.sv
/*
 * Edge detector for one external wakeup pin, steered by its 2-bit selector.
 * Assumes the pin is synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module lwu_pin_detect
   import lwu_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic arm_i,
   input wire logic watch_i,
   input wire logic [lwu_pkg::LWU_FIELD_W-1:0] sel_i,
   // Pin and result
   input wire logic pin_i,
   output logic hit_o
);

   logic prev;
   logic rise;
   logic fall;
   logic match;

   assign rise = pin_i & ~prev;
   assign fall = ~pin_i & prev;

   always_comb begin
      case (sel_i)
         LWU_SEL_RISE: match = rise;
         LWU_SEL_FALL: match = fall;
         LWU_SEL_ANY: match = rise | fall;
         default: match = 1'b0;
      endcase
   end

   // Reference level is held static outside low-leakage mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= 1'b0;
      end else if (arm_i || watch_i) begin
         prev <= pin_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_o <= 1'b0;
      end else begin
         hit_o <= watch_i & match;
      end
   end

endmodule : lwu_pin_detect

`default_nettype wire

// file: dv/lwu_edge_select_monitor.sv
/* Port checks of lwu_edge_select.
   Assumes one clock; either reset disables the checks. */
`timescale 1ns/10ps
`default_nettype none
module lwu_edge_select_monitor
   import lwu_pkg::*;
(
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic chip_rst_i,
   // Bus
   input wire lwu_pkg::lwu_wb_req_s wb_req_i,
   input wire logic wb_priv_i,
   input wire lwu_pkg::lwu_wb_rsp_s wb_rsp_o,
   // Pins
   input wire logic low_leak_mode_i,
   input wire logic [lwu_pkg::LWU_PIN_N-1:0] wake_pin_i,
   input wire logic [lwu_pkg::LWU_PIN_N-1:0] pin_wake_o,
   input wire logic wake_o
);
   import lwu_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i || chip_rst_i);
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && !wb_rsp_o.err;
   endsequence
   sequence s_quiet;
      (pin_wake_o == '0) [*3];
   endsequence
   ////////////////////////////////////////
   chk_bus_answer:
      assert property (s_take |=> wb_rsp_o.ack ^ wb_rsp_o.err)
      else $error("no single answer");
   chk_ack_pulse:
      assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack too long");
   chk_user_write:
      assert property (s_take ##0 (wb_req_i.we && !wb_priv_i) |=> wb_rsp_o.err)
      else $error("user write taken");
   chk_bad_addr:
      assert property (s_take ##0 (wb_req_i.adr[1:0] != 2'h0) |=> wb_rsp_o.err)
      else $error("misaligned taken");
   chk_read_top:
      assert property (wb_rsp_o.ack && !wb_req_i.we |-> wb_rsp_o.dat[31:13] == '0)
      else $error("upper read bits set");
   chk_hit_edge:
      assert property (pin_wake_o != '0
         |-> (pin_wake_o & ($past(wake_pin_i) ~^ $past(wake_pin_i, 2))) == '0)
      else $error("hit without pin change");
   chk_hit_wake:
      assert property (low_leak_mode_i && pin_wake_o != '0 |=> wake_o)
      else $error("hit without wake");
   chk_mode_quiet:
      assert property ((!low_leak_mode_i) [*3] |-> pin_wake_o == '0)
      else $error("hit outside mode");
   chk_wake_drop:
      assert property (!low_leak_mode_i |=> !wake_o)
      else $error("wake kept");
   chk_entry_quiet:
      assert property ($rose(low_leak_mode_i) |-> s_quiet)
      else $error("hit during arming");
endmodule : lwu_edge_select_monitor
bind lwu_edge_select lwu_edge_select_monitor u_mon (
   .clk_i(clk_i), .rst_i(rst_i), .chip_rst_i(chip_rst_i), .wb_req_i(wb_req_i),
   .wb_priv_i(wb_priv_i), .wb_rsp_o(wb_rsp_o), .low_leak_mode_i(low_leak_mode_i),
   .wake_pin_i(wake_pin_i), .pin_wake_o(pin_wake_o), .wake_o(wake_o));
`default_nettype wire

// file: dv/lwu_pin_model.sv
/* Model of the twelve external wakeup pins.
   Levels change only just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module lwu_pin_model
   import lwu_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Toggle mask from the bench
   input wire logic [lwu_pkg::LWU_PIN_N-1:0] flip_i,
   // Pin levels
   output logic [lwu_pkg::LWU_PIN_N-1:0] pin_o
);
   import lwu_pkg::*;
   logic [LWU_PIN_N-1:0] level = '0;
   always @(posedge clk_i) begin
      level <= level ^ flip_i;
   end
   assign pin_o = level;
endmodule : lwu_pin_model
`default_nettype wire

// file: dv/tb_lwu_edge_select.sv
/* Bench of lwu_edge_select: registers, resets and pin detection.
   Pins come from lwu_pin_model; results are checked through queues. */
`timescale 1ns/10ps
`default_nettype none
module tb_lwu_edge_select;
   import lwu_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic chip_rst_i = 1'b1;
   logic prv = 1'b0;
   logic mode = 1'b0;
   logic wake;
   logic [11:0] flip = '0;
   logic [11:0] pins;
   logic [11:0] hit;
   logic [23:0] cfg;
   logic [33:0] exp_w;
   logic [33:0] wq[$];
   logic [11:0] pq[$];
   lwu_wb_req_s req = '0;
   lwu_wb_rsp_s rsp;
   int error_cnt = 0;
   int tests_run = 0;
   always #5 clk_i = ~clk_i;
   lwu_pin_model u_pins (.clk_i(clk_i), .flip_i(flip), .pin_o(pins));
   lwu_edge_select uut (.clk_i(clk_i), .rst_i(rst_i), .chip_rst_i(chip_rst_i),
      .wb_req_i(req), .wb_priv_i(prv), .wb_rsp_o(rsp), .low_leak_mode_i(mode),
      .wake_pin_i(pins), .pin_wake_o(hit), .wake_o(wake));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("compares %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // One classic cycle; the expectation is queued first
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic p, input logic e, input logic [31:0] x);
      int n;
      n = 0;
      wq.push_back({!w && !e, e, x});
      @(posedge clk_i);
      req <= {2'b11, w, a, 4'hf, d};
      prv <= p;
      @(posedge clk_i);
      while (!(rsp.ack || rsp.err) && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (!(rsp.ack || rsp.err))
         error_cnt++;
      req <= '0;
   endtask : wb
   task automatic regs(input logic w, input logic [23:0] c);
      for (int i = 0; i < 3; i++)
         wb(w, 8'(4 * i + 4), {24'h0, c[8 * i +: 8]}, 1'b1, 1'b0, {24'h0, c[8 * i +: 8]});
   endtask : regs
   function automatic logic [11:0] hits(input logic [23:0] c, input logic r);
      for (int k = 0; k < 12; k++)
         hits[k] = c[2 * k + (r ? 0 : 1)];
   endfunction : hits
   task automatic toggle(input logic en);
      logic [11:0] m;
      m = hits(cfg, !pins[0]);
      if (en && m != '0)
         pq.push_back(m);
      @(posedge clk_i);
      flip <= '1;
      @(posedge clk_i);
      flip <= '0;
      repeat (4) @(posedge clk_i);
   endtask : toggle
   ////////////////////////////////////////
   always @(posedge clk_i) begin
      if (rsp.ack || rsp.err) begin
         exp_w = wq.pop_front();
         chk(32'(rsp.err), 32'(exp_w[32]));
         if (exp_w[33])
            chk(rsp.dat, exp_w[31:0]);
      end
      if (hit != '0)
         chk(32'(hit), 32'(pq.pop_front()));
   end
   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end
   initial begin
      void'($urandom(62));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      chip_rst_i <= 1'b0;
      regs(1'b0, '0);
      for (int t = 0; t < 4; t++) begin
         cfg = (t == 0) ? 24'h1be4e4 : 24'($urandom);
         regs(1'b1, cfg);
         regs(1'b0, cfg);
         @(posedge clk_i);
         mode <= 1'b1;
         repeat (4) @(posedge clk_i);
         toggle(1'b1);
         toggle(1'b1);
         chk(32'(wake), 32'(|cfg));
         mode <= 1'b0;
         repeat (3) @(posedge clk_i);
         chk(32'(wake), 32'h0);
         toggle(1'b0);
         $display("pin test %0d done", t);
      end
      wb(1'b1, 8'h04, 32'h000000ff, 1'b0, 1'b1, '0);
      wb(1'b0, 8'h04, '0, 1'b0, 1'b0, {24'h0, cfg[7:0]});
      wb(1'b0, 8'h14, '0, 1'b1, 1'b1, '0);
      wb(1'b1, 8'h05, '0, 1'b1, 1'b1, '0);
      wb(1'b0, 8'h10, '0, 1'b1, 1'b0, 32'(hits(cfg, 1'b1) | hits(cfg, 1'b0)));
      $display("bus error test done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      regs(1'b0, cfg);
      chip_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chip_rst_i <= 1'b0;
      regs(1'b0, '0);
      $display("reset test done");
      repeat (3) @(posedge clk_i);
      chk(32'(wq.size()), 32'h0);
      chk(32'(pq.size()), 32'h0);
      end_sim();
   end
endmodule : tb_lwu_edge_select
`default_nettype wire

// file: inc/lwu_pkg.sv
/*
 * Shared definitions of the low-leakage wakeup unit pin edge-select bank:
 * register indices, field layout, selector codes, bus carriers and states.
 * Assumes a 32-bit classic Wishbone master with byte-lane selects.
 */
package lwu_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int LWU_REG_W = 8;
   localparam int LWU_PIN_N = 12;
   localparam int LWU_FIELD_W = 2;
   localparam int LWU_ADR_W = 8;
   localparam int LWU_DAT_W = 32;
   localparam int LWU_SEL_W = 4;
   localparam int LWU_STAT_W = 13;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [LWU_ADR_W-1:0] LWU_IDX_PINS_7_4 = 8'h01;
   localparam logic [LWU_ADR_W-1:0] LWU_IDX_PINS_11_8 = 8'h02;
   localparam logic [LWU_ADR_W-1:0] LWU_IDX_PINS_15_12 = 8'h03;
   localparam logic [LWU_ADR_W-1:0] LWU_IDX_STATUS = 8'h04;
   localparam logic [1:0] LWU_ADR_ALIGN = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and field positions
   localparam logic [LWU_REG_W-1:0] LWU_CFG_RESET = 8'h00;
   localparam int LWU_STAT_WATCH_BIT = 12;

   ////////////////////////////////////////////////////////////////////////
   // Selector codes of one pin field
   localparam logic [LWU_FIELD_W-1:0] LWU_SEL_OFF = 2'h0;
   localparam logic [LWU_FIELD_W-1:0] LWU_SEL_RISE = 2'h1;
   localparam logic [LWU_FIELD_W-1:0] LWU_SEL_FALL = 2'h2;
   localparam logic [LWU_FIELD_W-1:0] LWU_SEL_ANY = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      LWU_IDLE,
      LWU_ARM,
      LWU_WATCH
   } lwu_state_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [LWU_ADR_W-1:0] adr;
      logic [LWU_SEL_W-1:0] sel;
      logic [LWU_DAT_W-1:0] dat;
   } lwu_wb_req_s;

   typedef struct packed {
      logic ack;
      logic err;
      logic [LWU_DAT_W-1:0] dat;
   } lwu_wb_rsp_s;

   typedef struct packed {
      logic hit;
      logic cfg;
      logic [1:0] slot;
   } lwu_decode_s;

endpackage : lwu_pkg
